// ---- verilog/csp_defs.vh ----
// Purpose: shared constants of the codec serial framing port
// Assumes: included by bare name from every design file
// Notes: frame lengths in shift clock bit periods
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

`define CSP_WORD_BITS 16
`define CSP_BYTE_BITS 8
`define CSP_CNT_W 5
`define CSP_LAST_BIT 5'h0f
`define CSP_BYTE_LAST 5'h07

// control register layout and reset value
`define CSP_CTRL_BIT11 11
`define CSP_CTRL_RESET 16'h02e4

// low two bits of a primary dac word that ask for a secondary frame
`define CSP_SEC_REQ 2'h3

// synchroniser lanes
`define CSP_SYN_W 5
`define CSP_SYN_SCLK 0
`define CSP_SYN_DIN 1
`define CSP_SYN_SEC 2
`define CSP_SYN_BYTE 3
`define CSP_SYN_DUAL 4

// fifo defaults
`define CSP_FIFO_DEPTH 8
`define CSP_FIFO_AW 3

`endif

// ---- verilog/csp_fifo.v ----
// Purpose: sample buffer between converter side and serial shifter
// Assumes: one clock; in_ready and out_data come from registers
// Notes: output stage adds one word of capacity beyond DEPTH
`timescale 1ns/1ps
`include "csp_defs.vh"

module csp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = `CSP_FIFO_DEPTH,
  parameter AW = `CSP_FIFO_AW
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
reg [AW:0] next_count;
wire push;
wire pop;

assign push = in_valid && in_ready;
// refill the output register whenever it is empty or being drained
assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

always @* begin
  next_count = count;
  if (push && !pop) begin
    next_count = count + {{AW{1'b0}}, 1'b1};
  end else if (pop && !push) begin
    next_count = count - {{AW{1'b0}}, 1'b1};
  end
end

always @(posedge clk) begin
  if (push) begin
    mem[wr_ptr] <= in_data;
  end
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    wr_ptr <= {AW{1'b0}};
    rd_ptr <= {AW{1'b0}};
    count <= {(AW+1){1'b0}};
    in_ready <= 1'b1;
    out_valid <= 1'b0;
    out_data <= {WIDTH{1'b0}};
  end else begin
    count <= next_count;
    // registered ready, so the source sees full without a combinational path
    in_ready <= (next_count != DEPTH[AW:0]);
    if (push) begin
      wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} : wr_ptr + {{(AW-1){1'b0}}, 1'b1};
    end
    if (pop) begin
      out_data <= mem[rd_ptr];
      out_valid <= 1'b1;
      rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} : rd_ptr + {{(AW-1){1'b0}}, 1'b1};
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
end

endmodule // csp_fifo

// ---- verilog/csp_serial_port.v ----
// Purpose: frame syncs, strobes and bit shifting of the codec serial port
// Assumes: shift clock generated outside, sampled here; host samples on its falling edge
// Notes: outputs change on rising shift clock edges, dac input is taken on falling ones
`timescale 1ns/1ps
`include "csp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - dual-word mode drives pin from control bit 11
// - reset clears control bit 11, pin low
// - pin follows control bit 11 immediately
// - word format: one low end strobe pulse
// - byte format: strobe low from the end of the first byte to the end of the frame
// - secondary sync high during primary frames
// - secondary sync copies transmit sync in secondary
// - receive sync low while sample bits shift
// - msb placed before receive sync falls
// - transmit sync low during inbound transfer
// - secondary frames forward secondary data input
// - all bits timed by the shift clock
module csp_serial_port #(
  parameter WIDTH = `CSP_WORD_BITS,
  parameter FIFO_DEPTH = `CSP_FIFO_DEPTH,
  parameter FIFO_AW = `CSP_FIFO_AW
) (
  input wire clk,
  input wire rst,
  input wire shift_clk,
  input wire dac_serial_in,
  input wire secondary_data_in,
  input wire byte_format_sel,
  input wire dual_word_sel,
  input wire [WIDTH-1:0] sample_data,
  input wire sample_valid,
  output wire sample_ready,
  output reg sample_serial_out,
  output reg receive_frame_sync,
  output reg transmit_frame_sync,
  output reg secondary_frame_sync,
  output reg end_of_receive_strobe,
  output reg bit_eleven_pin,
  output reg [WIDTH-1:0] dac_word,
  output reg dac_word_valid,
  output reg [WIDTH-1:0] control_word
);

localparam ST_IDLE = 4'h1;
localparam ST_LEAD = 4'h2;
localparam ST_SHIFT = 4'h4;
localparam ST_DONE = 4'h8;

// one step of a frame bit counter, shared by both directions
function [`CSP_CNT_W-1:0] cnt_inc;
  input [`CSP_CNT_W-1:0] value;
  begin
    cnt_inc = value + {{(`CSP_CNT_W-1){1'b0}}, 1'b1};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [`CSP_SYN_W-1:0] syn_meta;
reg [`CSP_SYN_W-1:0] syn;
reg sclk_prev;
wire sclk_rise;
wire sclk_fall;
wire din;
wire sec_in;
wire byte_mode;
wire dual_mode;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    syn_meta <= {`CSP_SYN_W{1'b0}};
    syn <= {`CSP_SYN_W{1'b0}};
    sclk_prev <= 1'b0;
  end else begin
    syn_meta <= {dual_word_sel, byte_format_sel, secondary_data_in, dac_serial_in, shift_clk};
    syn <= syn_meta;
    sclk_prev <= syn[`CSP_SYN_SCLK];
  end
end

// edges seen on the second stage only; adds two cycles of latency to every bit
assign sclk_rise = syn[`CSP_SYN_SCLK] && !sclk_prev;
assign sclk_fall = !syn[`CSP_SYN_SCLK] && sclk_prev;
assign din = syn[`CSP_SYN_DIN];
assign sec_in = syn[`CSP_SYN_SEC];
assign byte_mode = syn[`CSP_SYN_BYTE];
assign dual_mode = syn[`CSP_SYN_DUAL];

////////////////////////////////////////////////////////////////////////////////
// sample buffer
wire [WIDTH-1:0] fifo_data;
wire fifo_valid;
reg fifo_pop;

csp_fifo #(
  .WIDTH(WIDTH),
  .DEPTH(FIFO_DEPTH),
  .AW(FIFO_AW)
) u_fifo (
  .clk(clk),
  .rst(rst),
  .in_data(sample_data),
  .in_valid(sample_valid),
  .in_ready(sample_ready),
  .out_data(fifo_data),
  .out_valid(fifo_valid),
  .out_ready(fifo_pop)
);

////////////////////////////////////////////////////////////////////////////////
// inbound word assembly and control register
reg [WIDTH-1:0] rx_shift;
reg [`CSP_CNT_W-1:0] rx_cnt;
reg sec_frame;
reg sec_pending;
reg [WIDTH-1:0] next_ctrl;
wire rx_take;
wire rx_last;
wire [WIDTH-1:0] rx_word;

assign rx_take = sclk_fall && !transmit_frame_sync;
assign rx_last = rx_take && (rx_cnt == `CSP_LAST_BIT);
assign rx_word = {rx_shift[WIDTH-2:0], din};

always @* begin
  next_ctrl = control_word;
  // secondary frames carry control words; primary frames carry dac data
  if (rx_last && sec_frame) begin
    next_ctrl = rx_word;
  end
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    rx_shift <= {WIDTH{1'b0}};
    rx_cnt <= {`CSP_CNT_W{1'b0}};
    control_word <= `CSP_CTRL_RESET;
    bit_eleven_pin <= 1'b0;
    dac_word <= {WIDTH{1'b0}};
    dac_word_valid <= 1'b0;
  end else begin
    dac_word_valid <= 1'b0;
    control_word <= next_ctrl;
    // pin fed from the next value so it moves on the same edge as the register
    bit_eleven_pin <= dual_mode && next_ctrl[`CSP_CTRL_BIT11];
    if (transmit_frame_sync) begin
      rx_cnt <= {`CSP_CNT_W{1'b0}};
    end else if (rx_take) begin
      rx_shift <= rx_word;
      rx_cnt <= cnt_inc(rx_cnt);
      if (rx_last && !sec_frame) begin
        dac_word <= rx_word;
        dac_word_valid <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// frame sequencer, acts on rising shift clock edges; a secondary request is latched on a falling one
reg [3:0] state;
reg [WIDTH-1:0] tx_shift;
reg [`CSP_CNT_W-1:0] bit_cnt;
wire strobes_on;

// end strobe is only meaningful in word/byte mode, idle high otherwise
assign strobes_on = !dual_mode && !sec_frame;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    state <= ST_IDLE;
    tx_shift <= {WIDTH{1'b0}};
    bit_cnt <= {`CSP_CNT_W{1'b0}};
    sec_frame <= 1'b0;
    sec_pending <= 1'b0;
    fifo_pop <= 1'b0;
    sample_serial_out <= 1'b0;
    receive_frame_sync <= 1'b1;
    transmit_frame_sync <= 1'b1;
    secondary_frame_sync <= 1'b1;
    end_of_receive_strobe <= 1'b1;
  end else begin
    fifo_pop <= 1'b0;
    if (rx_last && !sec_frame && dual_mode && (rx_word[1:0] == `CSP_SEC_REQ)) begin
      sec_pending <= 1'b1;
    end
    if (sclk_rise) begin
      case (state)
        ST_IDLE: begin
          sample_serial_out <= 1'b0;
          if (fifo_valid && !fifo_pop) begin
            tx_shift <= fifo_data;
            sample_serial_out <= fifo_data[WIDTH-1];
            fifo_pop <= 1'b1;
            sec_frame <= 1'b0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          // syncs fall one bit period after the msb is on the line
          receive_frame_sync <= 1'b0;
          transmit_frame_sync <= 1'b0;
          secondary_frame_sync <= !sec_frame;
          if (sec_frame) begin
            sample_serial_out <= sec_in;
          end
          bit_cnt <= {`CSP_CNT_W{1'b0}};
          state <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (bit_cnt == `CSP_LAST_BIT) begin
            receive_frame_sync <= 1'b1;
            transmit_frame_sync <= 1'b1;
            secondary_frame_sync <= 1'b1;
            end_of_receive_strobe <= !(strobes_on && !byte_mode);
            state <= ST_DONE;
          end else begin
            bit_cnt <= cnt_inc(bit_cnt);
            tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
            sample_serial_out <= sec_frame ? sec_in : tx_shift[WIDTH-2];
            if (bit_cnt == `CSP_BYTE_LAST && strobes_on && byte_mode) begin
              end_of_receive_strobe <= 1'b0;
            end
          end
        end
        ST_DONE: begin
          end_of_receive_strobe <= 1'b1;
          if (sec_pending && dual_mode) begin
            sec_pending <= 1'b0;
            sec_frame <= 1'b1;
            sample_serial_out <= sec_in;
            state <= ST_LEAD;
          end else begin
            sec_pending <= 1'b0;
            sec_frame <= 1'b0;
            sample_serial_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
end

endmodule // csp_serial_port

// ---- verification/csp_serial_port_asserts.sv ----
// Purpose: port checks of csp_serial_port
// Assumes: shift clock period is 8 clk
// Notes: bound from the bench
`timescale 1ns/1ps
module csp_serial_port_asserts #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst,
  input wire shift_clk,
  input wire byte_format_sel,
  input wire dual_word_sel,
  input wire sample_serial_out,
  input wire receive_frame_sync,
  input wire transmit_frame_sync,
  input wire secondary_frame_sync,
  input wire end_of_receive_strobe,
  input wire bit_eleven_pin,
  input wire [WIDTH-1:0] control_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reg [7:0] lo_fs;
  reg [7:0] lo_eo;
  // run lengths of low levels
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_fs <= 8'h00;
      lo_eo <= 8'h00;
    end else begin
      lo_fs <= receive_frame_sync ? 8'h00 : lo_fs + 8'h01;
      lo_eo <= end_of_receive_strobe ? 8'h00 : lo_eo + 8'h01;
    end
  end
  AST_PIN: assert property ($changed(control_word) |-> bit_eleven_pin == control_word[11])
    else $error("pin differs from control bit");
  AST_RST: assert property ($past(rst) |-> !bit_eleven_pin && !control_word[11])
    else $error("control bit not clear after reset");
  AST_WPULSE: assert property ($fell(end_of_receive_strobe) && !byte_format_sel |->
    ##1 !end_of_receive_strobe [*7] ##1 end_of_receive_strobe)
    else $error("word strobe not one bit period");
  AST_BSPAN: assert property ($rose(end_of_receive_strobe) && byte_format_sel |->
    lo_eo >= 8'h38 && lo_eo <= 8'h48)
    else $error("byte strobe span wrong");
  AST_FSDP: assert property (!dual_word_sel |-> secondary_frame_sync)
    else $error("secondary sync low in primary");
  AST_FSDC: assert property ($changed(secondary_frame_sync) |-> secondary_frame_sync == transmit_frame_sync)
    else $error("secondary sync not a copy");
  AST_FSR: assert property ($rose(receive_frame_sync) |-> lo_fs == 8'h80)
    else $error("receive sync not 16 periods");
  AST_MSB: assert property ($fell(receive_frame_sync) |-> $stable(sample_serial_out))
    else $error("data moved as sync fell");
  AST_FSX: assert property (transmit_frame_sync == receive_frame_sync)
    else $error("transmit and receive syncs differ");
  AST_EDGE: assert property ($changed(receive_frame_sync) || $changed(end_of_receive_strobe) |->
    $past(shift_clk) && !$past(shift_clk, 5))
    else $error("sync moved off a shift edge");
endmodule // csp_serial_port_asserts

// ---- verification/csp_host_model.sv ----
// Purpose: host serial port facing csp_serial_port
// Assumes: syncs active low
// Notes: idle input line toggles each bit
`timescale 1ns/1ps
module csp_host_model (
  input wire shift_clk,
  input wire receive_frame_sync,
  input wire transmit_frame_sync,
  input wire sample_serial_out,
  input wire [15:0] tx_word,
  output reg dac_serial_in = 1'b0,
  output reg [15:0] rx_word = 16'h0000
);
  integer idx = 0;
  reg started = 1'b0;
  // one process drives the line: idle toggling, then the word msb first
  always @(posedge shift_clk or negedge transmit_frame_sync) begin
    if (transmit_frame_sync) begin
      started = 1'b0;
      dac_serial_in = ~dac_serial_in;
    end else if (!started) begin
      started = 1'b1;
      idx = 15;
      dac_serial_in = tx_word[15];
    end else if (idx > 0) begin
      idx = idx - 1;
      dac_serial_in = tx_word[idx];
    end
  end
  always @(negedge shift_clk)
    if (!receive_frame_sync)
      rx_word = {rx_word[14:0], sample_serial_out};
endmodule // csp_host_model

// ---- verification/csp_serial_port_tb.sv ----
// Purpose: self-checking bench of csp_serial_port
// Assumes: shift clock 80 ns, unrelated phase
// Notes: host model answers every frame
`timescale 1ns/1ps
module csp_serial_port_tb;
  reg clk = 0;
  reg rst = 1;
  reg shift_clk = 0;
  reg secondary_data_in = 0;
  reg byte_format_sel = 0;
  reg dual_word_sel = 0;
  reg sample_valid = 0;
  reg [15:0] sample_data = 16'h0000;
  reg [15:0] tx_word = 16'h0000;
  wire dac_serial_in, sample_ready, sample_serial_out, receive_frame_sync, transmit_frame_sync;
  wire secondary_frame_sync, end_of_receive_strobe, bit_eleven_pin, dac_word_valid;
  wire [15:0] dac_word, control_word, rx_word;
  integer mismatches = 0;
  integer checks_done = 0;
  integer n;
  integer k;
  integer lw;
  csp_serial_port dut (
    .clk(clk),
    .rst(rst),
    .shift_clk(shift_clk),
    .dac_serial_in(dac_serial_in),
    .secondary_data_in(secondary_data_in),
    .byte_format_sel(byte_format_sel),
    .dual_word_sel(dual_word_sel),
    .sample_data(sample_data),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready),
    .sample_serial_out(sample_serial_out),
    .receive_frame_sync(receive_frame_sync),
    .transmit_frame_sync(transmit_frame_sync),
    .secondary_frame_sync(secondary_frame_sync),
    .end_of_receive_strobe(end_of_receive_strobe),
    .bit_eleven_pin(bit_eleven_pin),
    .dac_word(dac_word),
    .dac_word_valid(dac_word_valid),
    .control_word(control_word)
  );
  csp_host_model host (
    .shift_clk(shift_clk),
    .receive_frame_sync(receive_frame_sync),
    .transmit_frame_sync(transmit_frame_sync),
    .sample_serial_out(sample_serial_out),
    .tx_word(tx_word),
    .dac_serial_in(dac_serial_in),
    .rx_word(rx_word)
  );
  initial forever #5 clk = ~clk;
  initial #3 forever #40 shift_clk = ~shift_clk;
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("FAIL %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task check_bound(input integer used, input integer lim);
    begin
      if (used == lim) begin
        chk("timeout", 16'h0001, 16'h0000);
        give_verdict;
      end
    end
  endtask
  // counts clk cycles of one low stretch of the end strobe
  task measure_strobe(input [15:0] exp_low);
    begin
      n = 0;
      while (end_of_receive_strobe !== 1'b0 && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      check_bound(n, 300);
      lw = 0;
      while (end_of_receive_strobe === 1'b0 && lw < 300) begin
        @(posedge clk);
        lw = lw + 1;
      end
      check_bound(lw, 300);
      chk("strobe_low", exp_low, lw[15:0]);
    end
  endtask
  task wait_dac;
    begin
      n = 0;
      while (dac_word_valid !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 3000) begin
        chk("timeout", 16'h0001, 16'h0000);
        give_verdict;
      end
      @(posedge clk);
    end
  endtask
  task send(input [15:0] s, input [15:0] t);
    begin
      tx_word <= t;
      sample_data <= s;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      wait_dac;
    end
  endtask
  task t_reset;
    begin
      chk("ctrl", 16'h02e4, control_word);
      chk("pin", 16'h0000, {15'h0000, bit_eleven_pin});
      chk("syncs", 16'h0003, {14'h0000, receive_frame_sync, secondary_frame_sync});
      $display("test reset done");
    end
  endtask
  task t_word;
    begin
      send(16'ha5c3, 16'h1234);
      chk("dac", 16'h1234, dac_word);
      chk("rx", 16'ha5c3, rx_word);
      measure_strobe(16'h0008);
      $display("test word done");
    end
  endtask
  task t_dual;
    begin
      dual_word_sel <= 1'b1;
      secondary_data_in <= 1'b1;
      send(16'h8001, 16'h0003);
      chk("dac", 16'h0003, dac_word);
      tx_word <= 16'h0800;
      n = 0;
      while (secondary_frame_sync !== 1'b0 && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      check_bound(n, 300);
      chk("fsd_fsx", 16'h0000, {14'h0000, secondary_frame_sync, transmit_frame_sync});
      n = 0;
      while (control_word !== 16'h0800 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      check_bound(n, 3000);
      @(posedge clk);
      chk("ctrl", 16'h0800, control_word);
      chk("pin", 16'h0001, {15'h0000, bit_eleven_pin});
      chk("sec", 16'hffff, rx_word);
      // let the secondary frame close before leaving dual mode
      repeat (40) @(posedge clk);
      dual_word_sel <= 1'b0;
      $display("test dual done");
    end
  endtask
  task t_fill;
    begin
      byte_format_sel <= 1'b1;
      tx_word <= 16'h1230;
      sample_data <= 16'h0f0f;
      sample_valid <= 1'b1;
      n = 0;
      while (sample_ready === 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      sample_valid <= 1'b0;
      chk("full", 16'h0000, {15'h0000, sample_ready});
      k = n - 1;
      // first frame's dac word lands while its strobe is still low
      measure_strobe(16'h0040);
      repeat (k - 1) wait_dac;
      chk("rx", 16'h0f0f, rx_word);
      chk("dac", 16'h1230, dac_word);
      chk("empty", 16'h0001, {15'h0000, sample_ready});
      $display("test fill done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_word;
    t_dual;
    t_fill;
    give_verdict;
  end
endmodule // csp_serial_port_tb
bind csp_serial_port csp_serial_port_asserts #(.WIDTH(WIDTH)) chk_u (
  .clk(clk),
  .rst(rst),
  .shift_clk(shift_clk),
  .byte_format_sel(byte_format_sel),
  .dual_word_sel(dual_word_sel),
  .sample_serial_out(sample_serial_out),
  .receive_frame_sync(receive_frame_sync),
  .transmit_frame_sync(transmit_frame_sync),
  .secondary_frame_sync(secondary_frame_sync),
  .end_of_receive_strobe(end_of_receive_strobe),
  .bit_eleven_pin(bit_eleven_pin),
  .control_word(control_word)
);
